// [hw/usb_interrupt_flag_logic.sv]
// usb interrupt flags, enables, line-state event detection and power control
//
// Contract
// - power enable low disables module, outputs inactive, pins released, analog off
// - flags 7:0 set by hardware, cleared by writing one, zero keeps, reset zero; here bit 1 ignores writes and follows the enabled errors
// - bits 31:8 of flag and enable registers read as zero
// - stall flag set on stall handshake in host or device mode
// - attach flag set when a peripheral attach is detected
// - attach valid only in host role, 2.5 us quiet, line not se0
// - wakeup flag set after k-state held for 2.5 us
// - bus quiet flag set after idle line for 3 ms
// - token done flag set when token ends; status shows its endpoint info
// - clearing token done flag advances the transfer status queue
// - frame start flag on sof token as peripheral, frame threshold as host
// - error summary flag read-only, set only by enabled error conditions
// - device role: bit 0 set on valid bus reset
// - host role: bit 0 set on peripheral removal
// - enable register bits 7:0 read/write, reset zero, one per flag
// - errors reach interrupt only when error summary enable is set
// - suspend gates usb clock and lowers transceiver power, wakeup detect stays
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module usb_interrupt_flag_logic
  import usb_intr_pkg::*;
#(
  parameter int unsigned IDLE_COUNT = IDLE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        lineDp,
  input  wire logic        lineDm,
  input  wire logic        stallEvent,
  input  wire logic        sofEvent,
  input  wire logic        frameThreshold,
  input  wire logic        tokenDone,
  input  wire logic [7:0]  tokenStatus,
  input  wire logic [7:0]  errorStatus,
  output logic             irq,
  output logic             moduleEnabled,
  output logic             pinsOwned,
  output logic             analogOn,
  output logic             usbClockEnable,
  output logic             transceiverLowPower,
  output logic             hostRole,
  output logic [7:0]       errorEnables
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]            dpSync;
    logic [2:0]            dmSync;
    line_t                 lineState;
    logic [CNT_W-1:0]      stableCnt;
    logic                  attached;
    logic [7:0]            flags;
    logic [7:0]            enables;
    logic [7:0]            errEn;
    logic                  power;
    logic                  suspend;
    logic                  host;
    logic [XQ_AW-1:0]      xqRd;
    logic [XQ_AW-1:0]      xqWr;
    logic [2:0]            xqCnt;
    logic [XQ_DEPTH-1:0][7:0] xqMem;
    logic                  ack;
    logic [31:0]           rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  localparam logic [CNT_W-1:0] SETTLE_M1 = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] IDLE_M1   = CNT_W'(IDLE_COUNT - 1);
  localparam logic [CNT_W-1:0] CNT_MAX   = CNT_W'(IDLE_COUNT);

  function automatic line_t decodeLine(input logic dp, input logic dm);
    line_t l;
    case ({dp, dm})
      2'b00:   l = LINE_SE0;
      2'b10:   l = LINE_J;
      2'b01:   l = LINE_K;
      default: l = LINE_SE1;
    endcase
    return l;
  endfunction

  line_t            newLine;
  logic             stepped;
  logic             hitSettle;
  logic             hitIdle;
  logic [7:0]       setEv;
  logic [7:0]       clrMask;
  logic             wrTake;
  logic             push;
  logic             pop;
  logic             errSum;
  logic [31:0]      rdMux;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // first stage feeds only the second; third and second must agree
    s_d.dpSync = {s_q.dpSync[1:0], lineDp};
    s_d.dmSync = {s_q.dmSync[1:0], lineDm};
    newLine = s_q.lineState;
    if (s_q.dpSync[2] == s_q.dpSync[1] && s_q.dmSync[2] == s_q.dmSync[1]) begin
      newLine = decodeLine(s_q.dpSync[2], s_q.dmSync[2]);
    end
    stepped = s_q.power && newLine == s_q.lineState && s_q.stableCnt != CNT_MAX;
    hitSettle = stepped && s_q.stableCnt == SETTLE_M1;
    hitIdle   = stepped && s_q.stableCnt == IDLE_M1;
    if (!s_q.power) begin
      s_d.stableCnt = '0;
      s_d.lineState = newLine;
    end else if (newLine != s_q.lineState) begin
      s_d.lineState = newLine;
      s_d.stableCnt = '0;
    end else if (stepped) begin
      s_d.stableCnt = s_q.stableCnt + 1'b1;
    end

    // bus events
    setEv = '0;
    setEv[BIT_STALL]  = s_q.power && stallEvent;
    setEv[BIT_ATTACH] = s_q.host && hitSettle && s_q.lineState != LINE_SE0 && !s_q.attached;
    setEv[BIT_WAKE]   = hitSettle && s_q.lineState == LINE_K;
    setEv[BIT_QUIET]  = hitIdle && s_q.lineState == LINE_J;
    setEv[BIT_FRAME]  = s_q.power && (s_q.host ? frameThreshold : sofEvent);
    // device: long se0 is bus reset; host: se0 after attach is removal
    setEv[BIT_BUSRST] = hitSettle && s_q.lineState == LINE_SE0 && (!s_q.host || s_q.attached);
    if (setEv[BIT_ATTACH]) begin
      s_d.attached = 1'b1;
    end else if (!s_q.host || (setEv[BIT_BUSRST] && s_q.host)) begin
      s_d.attached = 1'b0;
    end

    // bus slave: answer one cycle after the request appears
    wrTake = write && s_q.ack && byteenable[0];
    s_d.ack = (read || write) && !s_q.ack;
    clrMask = '0;
    if (wrTake && address == OFS_FLAGS) begin
      clrMask = writedata[7:0];
    end
    if (wrTake && address == OFS_ENABLES) begin
      s_d.enables = writedata[7:0];
    end
    if (wrTake && address == OFS_ERR_EN) begin
      s_d.errEn = writedata[7:0];
    end
    if (wrTake && address == OFS_CTRL) begin
      s_d.power   = writedata[CTL_POWER];
      s_d.suspend = writedata[CTL_SUSP];
      s_d.host    = writedata[CTL_HOST];
    end

    // transfer status queue; a full queue drops the new entry
    push = s_q.power && tokenDone && s_q.xqCnt != XQ_FULL;
    pop  = clrMask[BIT_TOKEN] && s_q.xqCnt != '0;
    if (push) begin
      s_d.xqMem[s_q.xqWr] = tokenStatus;
      s_d.xqWr = s_q.xqWr + 1'b1;
    end
    if (pop) begin
      s_d.xqRd = s_q.xqRd + 1'b1;
    end
    s_d.xqCnt = s_q.xqCnt + {2'b00, push} - {2'b00, pop};

    // set wins over clear
    s_d.flags = (s_q.flags & ~clrMask) | setEv;
    errSum = s_q.power && |(errorStatus & s_q.errEn);
    s_d.flags[BIT_ERR] = errSum;
    s_d.flags[BIT_TOKEN] = s_d.xqCnt != '0;

    rdMux = RD_ZERO;
    case (address)
      OFS_FLAGS:   rdMux[REG_W-1:0] = s_q.flags;
      OFS_ENABLES: rdMux[REG_W-1:0] = s_q.enables;
      OFS_ERR_EN:  rdMux[REG_W-1:0] = s_q.errEn;
      OFS_CTRL: begin
        rdMux[CTL_POWER] = s_q.power;
        rdMux[CTL_SUSP]  = s_q.suspend;
        rdMux[CTL_HOST]  = s_q.host;
      end
      OFS_XSTAT:   rdMux[REG_W-1:0] = s_q.xqMem[s_q.xqRd];
      default:     rdMux = RD_ZERO;
    endcase
    if (read && !s_q.ack) begin
      s_d.rdata = rdMux;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign waitrequest = (read || write) && !s_q.ack;
  assign readdata    = s_q.rdata;
  // error events only pass through enables bit 1, same as every flag
  assign irq = s_q.power && |(s_q.flags & s_q.enables);
  assign moduleEnabled       = s_q.power;
  assign pinsOwned           = s_q.power;
  assign analogOn            = s_q.power;
  assign usbClockEnable      = s_q.power && !s_q.suspend;
  assign transceiverLowPower = !s_q.power || s_q.suspend;
  assign hostRole            = s_q.host;
  assign errorEnables        = s_q.errEn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_w1c_clears;
    @(posedge clk_sys) disable iff (srst)
      (wrTake && address == OFS_FLAGS && writedata[BIT_STALL] && !stallEvent) |=> !s_q.flags[BIT_STALL];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("stall flag not cleared by one");

  property p_zero_keeps;
    @(posedge clk_sys) disable iff (srst)
      (wrTake && address == OFS_FLAGS && !writedata[BIT_QUIET] && s_q.flags[BIT_QUIET]) |=> s_q.flags[BIT_QUIET];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero write");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (srst)
      (read && !waitrequest && (address == OFS_FLAGS || address == OFS_ENABLES)) |-> readdata[31:REG_W] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits read nonzero");

  property p_stall_irq;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && stallEvent && s_q.enables[BIT_STALL] && !(wrTake && address != OFS_FLAGS)) |=> irq;
  endproperty
  a_stall_irq: assert property (p_stall_irq) else $error("stall did not raise interrupt");

  property p_off_quiet;
    @(posedge clk_sys) disable iff (srst)
      !moduleEnabled |-> (!irq && !pinsOwned && !usbClockEnable);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled module active");

  property p_wake_time;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_WAKE]) |-> ($past(s_q.stableCnt) == SETTLE_M1 && $past(s_q.lineState) == LINE_K);
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wakeup flag without settled k-state");

  property p_attach_host;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_ATTACH]) |-> ($past(s_q.host) && $past(s_q.lineState) != LINE_SE0);
  endproperty
  a_attach_host: assert property (p_attach_host) else $error("attach outside host role");

  property p_err_summary;
    @(posedge clk_sys) disable iff (srst)
      ##1 s_q.flags[BIT_ERR] == $past(s_q.power && |(errorStatus & s_q.errEn));
  endproperty
  a_err_summary: assert property (p_err_summary) else $error("error summary wrong");

  property p_queue_advance;
    @(posedge clk_sys) disable iff (srst)
      (pop && s_q.xqCnt > 3'h1) |=> (s_q.flags[BIT_TOKEN] && s_q.xqRd == XQ_AW'($past(s_q.xqRd) + 1'b1));
  endproperty
  a_queue_advance: assert property (p_queue_advance) else $error("token flag dropped with queue left");

  property p_suspend_clock;
    @(posedge clk_sys) disable iff (srst)
      (s_q.suspend && s_q.power) |-> (!usbClockEnable && transceiverLowPower);
  endproperty
  a_suspend_clock: assert property (p_suspend_clock) else $error("suspend left usb clock on");

  property p_stall_source;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_STALL]) |-> $past(s_q.power && stallEvent);
  endproperty
  a_stall_source: assert property (p_stall_source) else $error("stall flag without stall event");

  property p_frame_device;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && !s_q.host && sofEvent) |=> s_q.flags[BIT_FRAME];
  endproperty
  a_frame_device: assert property (p_frame_device) else $error("sof token did not set frame flag");

  property p_frame_host;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && s_q.host && frameThreshold) |=> s_q.flags[BIT_FRAME];
  endproperty
  a_frame_host: assert property (p_frame_host) else $error("frame threshold did not set frame flag");

  property p_token_set;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && tokenDone) |=> s_q.flags[BIT_TOKEN];
  endproperty
  a_token_set: assert property (p_token_set) else $error("token done did not set flag");

  property p_token_status;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && tokenDone && s_q.xqCnt == '0) |=> s_q.xqMem[s_q.xqRd] == $past(tokenStatus);
  endproperty
  a_token_status: assert property (p_token_status) else $error("queue head not the finished token");

  property p_token_last;
    @(posedge clk_sys) disable iff (srst)
      (pop && !push && s_q.xqCnt == 3'h1) |=> !s_q.flags[BIT_TOKEN];
  endproperty
  a_token_last: assert property (p_token_last) else $error("token flag kept with queue empty");

  property p_reset_detach;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_BUSRST]) |-> ($past(s_q.lineState) == LINE_SE0 && $past(!s_q.host || s_q.attached));
  endproperty
  a_reset_detach: assert property (p_reset_detach) else $error("bit 0 set without se0 event");

  property p_quiet_time;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_QUIET]) |-> ($past(s_q.stableCnt) == IDLE_M1 && $past(s_q.lineState) == LINE_J);
  endproperty
  a_quiet_time: assert property (p_quiet_time) else $error("quiet flag without long idle");

  property p_err_readonly;
    @(posedge clk_sys) disable iff (srst)
      (wrTake && writedata[BIT_ERR] && s_q.power && |(errorStatus & s_q.errEn)) |=> s_q.flags[BIT_ERR];
  endproperty
  a_err_readonly: assert property (p_err_readonly) else $error("error summary cleared by write");

  property p_off_no_set;
    @(posedge clk_sys) disable iff (srst)
      !s_q.power |=> !(|(s_q.flags & ~$past(s_q.flags)));
  endproperty
  a_off_no_set: assert property (p_off_no_set) else $error("flag set while module off");

  property p_attach_once;
    @(posedge clk_sys) disable iff (srst)
      $rose(s_q.flags[BIT_ATTACH]) |-> ($past(s_q.stableCnt) == SETTLE_M1 && !$past(s_q.attached));
  endproperty
  a_attach_once: assert property (p_attach_once) else $error("attach flag without settled line");

  property p_suspend_wake;
    @(posedge clk_sys) disable iff (srst)
      (s_q.power && s_q.suspend && hitSettle && s_q.lineState == LINE_K) |=> s_q.flags[BIT_WAKE];
  endproperty
  a_suspend_wake: assert property (p_suspend_wake) else $error("wakeup lost in suspend");

  property p_enable_write;
    @(posedge clk_sys) disable iff (srst)
      (wrTake && address == OFS_ENABLES) |=> s_q.enables == $past(writedata[REG_W-1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write did not land");

  property p_enable_hold;
    @(posedge clk_sys) disable iff (srst)
      !(wrTake && address == OFS_ENABLES) |=> $stable(s_q.enables);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enables changed without write");

endmodule // usb_interrupt_flag_logic

// [hw/usb_intr_pkg.sv]
// constants, register map and types of the usb interrupt flag logic
package usb_intr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned LINE_SETTLE_NS = 2500;
  localparam int unsigned IDLE_MS        = 3;
  localparam int unsigned SETTLE_CYC     = (LINE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned IDLE_CYC       = IDLE_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W          = 19;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_FLAGS   = 5'h00;
  localparam logic [4:0] OFS_ENABLES = 5'h04;
  localparam logic [4:0] OFS_ERR_EN  = 5'h08;
  localparam logic [4:0] OFS_CTRL    = 5'h0C;
  localparam logic [4:0] OFS_XSTAT   = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_STALL  = 7;
  localparam int unsigned BIT_ATTACH = 6;
  localparam int unsigned BIT_WAKE   = 5;
  localparam int unsigned BIT_QUIET  = 4;
  localparam int unsigned BIT_TOKEN  = 3;
  localparam int unsigned BIT_FRAME  = 2;
  localparam int unsigned BIT_ERR    = 1;
  localparam int unsigned BIT_BUSRST = 0;
  localparam int unsigned CTL_POWER  = 0;
  localparam int unsigned CTL_SUSP   = 1;
  localparam int unsigned CTL_HOST   = 2;
  localparam int unsigned REG_W      = 8;

  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // transfer status queue
  // ----------------------------------------------------------------
  localparam int unsigned XQ_DEPTH = 4;
  localparam int unsigned XQ_AW    = 2;
  localparam logic [2:0]  XQ_FULL  = 3'h4;

  typedef enum logic [1:0] {LINE_SE0, LINE_J, LINE_K, LINE_SE1} line_t;

endpackage

// [testbench/usb_bus_model.sv]
// usb bus model: drives the data line pair as host or peripheral
`timescale 1ns/1ps
module usb_bus_model
  import usb_intr_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  traffic,
  input  wire line_t hold,
  output logic       lineDp,
  output logic       lineDm
);
  logic [2:0] phase_q = 3'h0;
  line_t      state;
  // traffic flips j and k every 4 cycles, so no line timer can mature
  always @(posedge clk_sys) phase_q <= phase_q + 3'h1;
  always_comb state = traffic ? (phase_q[2] ? LINE_K : LINE_J) : hold;
  // full speed: j is d+ high, k is d- high, se0 both low
  assign lineDp = (state == LINE_J) || (state == LINE_SE1);
  assign lineDm = (state == LINE_K) || (state == LINE_SE1);
endmodule // usb_bus_model

// [testbench/usb_interrupt_flag_logic_bench.sv]
// self-checking bench of the usb interrupt flag logic
`timescale 1ns/1ps
module usb_interrupt_flag_logic_bench
  import usb_intr_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0]  byteenable = 4'hF;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  tokenStatus = 8'h00;
  logic [7:0]  errorStatus = 8'h00;
  logic        traffic = 1'b1;
  line_t       hold = LINE_J;
  logic [31:0] readdata;
  logic        waitrequest, irq, lineDp, lineDm, hostRole;
  logic        moduleEnabled, pinsOwned, analogOn, usbClockEnable, transceiverLowPower;
  logic [7:0]  errorEnables, s0, s1, e;
  logic [31:0] expQ[$];
  int          fails = 0;
  int          checksDone = 0;
  int          cycles = 0;

  // ----------------------------------------------------------------
  // design, bus model and shared tasks
  // ----------------------------------------------------------------
  usb_interrupt_flag_logic #(.IDLE_COUNT(400)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .lineDp(lineDp), .lineDm(lineDm), .stallEvent(ev[3]), .sofEvent(ev[2]), .frameThreshold(ev[1]),
    .tokenDone(ev[0]), .tokenStatus(tokenStatus), .errorStatus(errorStatus), .irq(irq),
    .moduleEnabled(moduleEnabled), .pinsOwned(pinsOwned), .analogOn(analogOn),
    .usbClockEnable(usbClockEnable), .transceiverLowPower(transceiverLowPower),
    .hostRole(hostRole), .errorEnables(errorEnables)
  );
  usb_bus_model bus_u (.clk_sys(clk_sys), .traffic(traffic), .hold(hold), .lineDp(lineDp), .lineDm(lineDm));

  initial forever #4 clk_sys = ~clk_sys;

  task automatic give_verdict;
    if (expQ.size() != 0) fails++;
    $display("comparisons %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge; released only after it
  task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic w;
    @(posedge clk_sys);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge clk_sys);
      w = waitrequest;
    end while (w !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    access(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    expQ.push_back(x);
    access(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  task automatic pulse(input logic [3:0] w, input logic [7:0] st);
    @(posedge clk_sys);
    ev <= w;
    tokenStatus <= st;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask

  task automatic line(input line_t s, input int n, input logic t);
    @(posedge clk_sys);
    traffic <= t;
    hold <= s;
    repeat (n) @(posedge clk_sys);
  endtask

  // order: irq, enabled, pins, analog, usb clock, low power, host
  task automatic outs(input logic [6:0] x);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({25'h000_0000, irq, moduleEnabled, pinsOwned, analogOn, usbClockEnable, transceiverLowPower, hostRole},
          {25'h000_0000, x});
  endtask

  // read data taken at the accepting edge against the oldest note
  always @(posedge clk_sys) begin
    if (read && !waitrequest) check(readdata, expQ.pop_front());
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(39358));
    s0 = 8'($urandom);
    s1 = 8'($urandom);
    e = 8'($urandom) | 8'h01;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_ENABLES, 32'h0000_0000);
    pulse(4'h8, s0);
    rd(OFS_FLAGS, 32'h0000_0000);
    outs(7'h02);
    wr(OFS_CTRL, 32'h0000_0001);
    outs(7'h3C);
    wr(OFS_ENABLES, 32'hFFFF_FFFF);
    rd(OFS_ENABLES, 32'h0000_00FF);
    access(1'b1, OFS_ENABLES, 32'h0000_0000, 4'h0);
    rd(OFS_ENABLES, 32'h0000_00FF);
    wr(OFS_ENABLES, {24'h00_0000, s1});
    rd(OFS_ENABLES, {24'h00_0000, s1});
    wr(OFS_ENABLES, 32'h0000_0000);
    rd(5'h14, 32'h0000_0000);
    pulse(4'hD, s0);
    pulse(4'h1, s1);
    rd(OFS_FLAGS, 32'h0000_008C);
    rd(OFS_XSTAT, {24'h00_0000, s0});
    wr(OFS_ENABLES, 32'h0000_0080);
    pulse(4'h8, s1);
    outs(7'h7C);
    // power off must silence irq although a flag and its enable stay set
    wr(OFS_CTRL, 32'h0000_0000);
    outs(7'h02);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_008C);
    wr(OFS_FLAGS, 32'h0000_0080);
    outs(7'h3C);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_XSTAT, {24'h00_0000, s1});
    rd(OFS_FLAGS, 32'h0000_000C);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_FLAGS, 32'h0000_0004);
    errorStatus <= e;
    wr(OFS_ERR_EN, {24'h00_0000, e});
    @(negedge clk_sys);
    check({24'h00_0000, errorEnables}, {24'h00_0000, e});
    wr(OFS_FLAGS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h0000_0006);
    wr(OFS_ENABLES, 32'h0000_0002);
    outs(7'h7C);
    wr(OFS_ERR_EN, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0004);
    outs(7'h3C);
    wr(OFS_FLAGS, 32'h0000_00FF);
    wr(OFS_ENABLES, 32'h0000_0000);
    line(LINE_SE0, 340, 1'b0);
    rd(OFS_FLAGS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0003);
    outs(7'h3A);
    line(LINE_K, 340, 1'b0);
    rd(OFS_FLAGS, 32'h0000_0021);
    wr(OFS_ENABLES, 32'h0000_0020);
    outs(7'h7A);
    wr(OFS_ENABLES, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    line(LINE_J, 200, 1'b0);
    rd(OFS_FLAGS, 32'h0000_0021);
    line(LINE_J, 250, 1'b0);
    rd(OFS_FLAGS, 32'h0000_0031);
    wr(OFS_FLAGS, 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0030);
    line(LINE_J, 1, 1'b1);
    wr(OFS_FLAGS, 32'h0000_00FF);
    wr(OFS_CTRL, 32'h0000_0005);
    outs(7'h3D);
    line(LINE_J, 330, 1'b0);
    pulse(4'h2, s0);
    rd(OFS_FLAGS, 32'h0000_0044);
    line(LINE_SE0, 340, 1'b0);
    rd(OFS_FLAGS, 32'h0000_0045);
    line(LINE_J, 1, 1'b1);
    repeat (4) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rd(OFS_FLAGS, 32'h0000_0000);
    outs(7'h02);
    give_verdict;
  end
endmodule // usb_interrupt_flag_logic_bench
